// file: hdl/caw_pkg.sv
// caw_pkg: constants and types for the clock alarm, weekday and trim block
// assumes an 8-bit special function register port on the core clock
package caw_pkg;

    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_TRIM = 8'h96;
    localparam logic [7:0] OFS_ALM_SUBSEC = 8'hf2;
    localparam logic [7:0] OFS_ALM_SEC = 8'hf3;
    localparam logic [7:0] OFS_ALM_MIN = 8'hf4;
    localparam logic [7:0] OFS_ALM_HOUR = 8'hf5;
    localparam logic [7:0] OFS_CTRL = 8'hf9;
    localparam logic [7:0] OFS_HOUR_CNT = 8'hfd;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int CTRL_IRQ_FLAG_BIT = 1;
    localparam int TRIM_FOUT_EN_BIT = 7;
    localparam int TRIM_LOAD_CAP_BIT = 6;

    // ------------------------------------------------------------
    // limits and reset values
    // ------------------------------------------------------------
    localparam logic [7:0] SUBSEC_MAX = 8'hff;
    localparam logic [7:0] SEC_MAX = 8'h3b;
    localparam logic [7:0] MIN_MAX = 8'h3b;
    localparam logic [4:0] HOUR_MAX = 5'h17;
    localparam logic [2:0] WDAY_LAST = 3'h7;
    localparam logic [2:0] WDAY_FIRST = 3'h1;
    localparam logic [2:0] WDAY_OFF = 3'h0;
    localparam logic [7:0] TRIM_BAD_VALUE = 8'h25;
    localparam logic [7:0] TRIM_RST = 8'h65;
    localparam logic [7:0] CTRL_RST = 8'h00;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int OSC_DIV_FOUT = 8;
    localparam int OSC_DIV_TICK = 128;
    localparam int FOUT_HALF = OSC_DIV_FOUT / 2;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } caw_sfr_req_t;

    typedef struct packed {
        logic [7:0] subsec;
        logic [7:0] sec;
        logic [7:0] min;
        logic [4:0] hour;
    } caw_time_t;

endpackage : caw_pkg

// file: hdl/caw_fout_div.sv
// caw_fout_div: divides the synchronised oscillator by eight for the pin
// assumes osc_edge_i pulses one core cycle per oscillator rising edge
`timescale 1ns/1ps
module caw_fout_div
    import caw_pkg::*;
(
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic osc_edge_i,
    input wire logic en_i,
    output logic fout_o
);
    logic [2:0] cnt_q;
    logic [2:0] cnt_d;
    logic fout_d;

    assign cnt_d = osc_edge_i ? cnt_q + 3'h1 : cnt_q;
    assign fout_d = en_i & (cnt_q >= 3'(FOUT_HALF));

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_q <= 3'h0;
            fout_o <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            fout_o <= fout_d;
        end
    end
endmodule : caw_fout_div

// file: hdl/caw_alarm.sv
// caw_alarm: alarm compare, weekday count and trim guard of the clock
// assumes time counts arrive on the core clock; osc and power pins are async
`timescale 1ns/1ps
module caw_alarm
    import caw_pkg::*;
(
    input wire logic mclk_i,
    input wire logic rst_b_i,
    input wire logic xtal_in_i,
    input wire logic retention_i,
    input wire caw_sfr_req_t sfr_req_i,
    input wire caw_time_t time_i,
    input wire logic hour_roll_i,
    output logic [7:0] sfr_rdata_o,
    output logic alarm_irq_o,
    output logic tick_o,
    output logic [2:0] weekday_field_o,
    output logic load_cap_select_o,
    output logic [2:0] trim_value_bits_o,
    output logic freq_out_pin_o,
    output logic freq_out_pin_oe_o
);
    // ------------------------------------------------------------
    // reset and input synchronisers
    // ------------------------------------------------------------
    logic [1:0] rst_sync_q;
    logic rst_n;
    logic [1:0] osc_sync_q;
    logic osc_prev_q;
    logic [1:0] ret_sync_q;
    logic retention;
    logic osc_edge;

    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rst_sync_q <= 2'b00;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            osc_sync_q <= 2'b00;
            osc_prev_q <= 1'b0;
            ret_sync_q <= 2'b00;
        end else begin
            osc_sync_q <= {osc_sync_q[0], xtal_in_i};
            osc_prev_q <= osc_sync_q[1];
            ret_sync_q <= {ret_sync_q[0], retention_i};
        end
    end
    assign osc_edge = osc_sync_q[1] & ~osc_prev_q;
    assign retention = ret_sync_q[1];

    // ------------------------------------------------------------
    // subsecond tick
    // ------------------------------------------------------------
    logic [6:0] tick_cnt_q;
    logic [6:0] tick_cnt_d;
    logic tick;

    assign tick = osc_edge & (tick_cnt_q == 7'(OSC_DIV_TICK - 1));
    assign tick_cnt_d = osc_edge ? tick_cnt_q + 7'h1 : tick_cnt_q;

    // ------------------------------------------------------------
    // register writes
    // ------------------------------------------------------------
    logic [7:0] alm_q [4];
    logic [7:0] ctrl_q;
    logic [7:0] trim_q;
    logic [2:0] wday_q;
    logic wr_ok;
    logic wr_ctrl;
    logic wr_trim;
    logic wr_hour;
    logic trim_good;
    logic [7:0] trim_d;
    logic [3:0] cmp_en;

    assign wr_ok = sfr_req_i.wr & ~retention;
    assign wr_ctrl = wr_ok & (sfr_req_i.addr == OFS_CTRL);
    assign wr_trim = wr_ok & (sfr_req_i.addr == OFS_TRIM);
    assign wr_hour = wr_ok & (sfr_req_i.addr == OFS_HOUR_CNT);
    assign trim_good = (sfr_req_i.wdata[5] != sfr_req_i.wdata[4])
                     & (sfr_req_i.wdata[3] != sfr_req_i.wdata[2])
                     & (sfr_req_i.wdata[1] != sfr_req_i.wdata[0]);
    assign trim_d = trim_good ? sfr_req_i.wdata
                  : {TRIM_BAD_VALUE[7], trim_q[TRIM_LOAD_CAP_BIT],
                     TRIM_BAD_VALUE[5:0]};
    assign cmp_en = {ctrl_q[4], ctrl_q[5], ctrl_q[6], ctrl_q[7]};

    // ------------------------------------------------------------
    // alarm compare
    // ------------------------------------------------------------
    logic [7:0] now [4];
    logic [7:0] lim [4];
    logic [3:0] fmatch;
    logic match;
    logic wr_alarm;
    logic fired_q;
    logic pend_q;
    logic flag_q;
    logic flag_d;
    logic fire;
    logic sw_clr;

    assign now[0] = time_i.subsec;
    assign now[1] = time_i.sec;
    assign now[2] = time_i.min;
    assign now[3] = {3'h0, time_i.hour};
    assign lim[0] = SUBSEC_MAX;
    assign lim[1] = SEC_MAX;
    assign lim[2] = MIN_MAX;
    assign lim[3] = {3'h0, HOUR_MAX};

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_field
            // disabled field matches; out-of-range never
            assign fmatch[gi] = ~cmp_en[gi]
                | ((alm_q[gi] == now[gi]) & (alm_q[gi] <= lim[gi]));
            always_ff @(posedge mclk_i or negedge rst_n) begin
                if (!rst_n) begin
                    alm_q[gi] <= 8'h00;
                end else if (wr_ok
                        && sfr_req_i.addr == OFS_ALM_SUBSEC + 8'(gi)) begin
                    alm_q[gi] <= sfr_req_i.wdata;
                end
            end
        end
    endgenerate

    assign match = (&fmatch) & (|cmp_en);
    assign wr_alarm = wr_ok & (sfr_req_i.addr >= OFS_ALM_SUBSEC)
                    & (sfr_req_i.addr <= OFS_ALM_HOUR);
    // synchronous on tick, asynchronous once after a write; one per tick
    assign fire = match & ((tick) | (pend_q & ~fired_q));
    assign sw_clr = wr_ctrl & ~sfr_req_i.wdata[CTRL_IRQ_FLAG_BIT];
    assign flag_d = (~|cmp_en) ? 1'b0
                  : fire ? 1'b1
                  : sw_clr ? 1'b0 : flag_q;

    // ------------------------------------------------------------
    // weekday
    // ------------------------------------------------------------
    logic [2:0] wday_d;

    assign wday_d = wr_hour ? sfr_req_i.wdata[7:5]
                  : ~hour_roll_i ? wday_q
                  : (wday_q == WDAY_OFF) ? WDAY_OFF
                  : (wday_q == WDAY_LAST) ? WDAY_FIRST
                  : wday_q + 3'h1;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            tick_cnt_q <= 7'h00;
            ctrl_q <= CTRL_RST;
            trim_q <= TRIM_RST;
            wday_q <= WDAY_OFF;
            fired_q <= 1'b0;
            pend_q <= 1'b0;
            flag_q <= 1'b0;
        end else begin
            tick_cnt_q <= tick_cnt_d;
            ctrl_q <= wr_ctrl ? sfr_req_i.wdata : ctrl_q;
            trim_q <= wr_trim ? trim_d : trim_q;
            wday_q <= wday_d;
            fired_q <= tick ? fire : (fired_q | fire);
            pend_q <= wr_alarm | wr_ctrl | (pend_q & ~fire & ~tick);
            flag_q <= flag_d;
        end
    end

    // ------------------------------------------------------------
    // read data and outputs
    // ------------------------------------------------------------
    logic [7:0] rd_d;
    logic [7:0] ctrl_rd;

    assign ctrl_rd = {ctrl_q[7:2], flag_q, ctrl_q[0]};
    assign rd_d = (sfr_req_i.addr == OFS_CTRL) ? ctrl_rd
                : (sfr_req_i.addr == OFS_TRIM) ? trim_q
                : (sfr_req_i.addr == OFS_ALM_SUBSEC) ? alm_q[0]
                : (sfr_req_i.addr == OFS_ALM_SEC) ? alm_q[1]
                : (sfr_req_i.addr == OFS_ALM_MIN) ? alm_q[2]
                : (sfr_req_i.addr == OFS_ALM_HOUR) ? alm_q[3]
                : (sfr_req_i.addr == OFS_HOUR_CNT)
                    ? {wday_q, time_i.hour} : 8'h00;

    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            sfr_rdata_o <= 8'h00;
            alarm_irq_o <= 1'b0;
            tick_o <= 1'b0;
            weekday_field_o <= WDAY_OFF;
            load_cap_select_o <= TRIM_RST[TRIM_LOAD_CAP_BIT];
            trim_value_bits_o <= 3'h0;
            freq_out_pin_oe_o <= 1'b0;
        end else begin
            sfr_rdata_o <= sfr_req_i.rd ? rd_d : 8'h00;
            alarm_irq_o <= flag_d;
            tick_o <= tick;
            weekday_field_o <= wday_d;
            load_cap_select_o <= trim_q[TRIM_LOAD_CAP_BIT];
            trim_value_bits_o <= {trim_q[5], trim_q[3], trim_q[1]};
            freq_out_pin_oe_o <= trim_q[TRIM_FOUT_EN_BIT];
        end
    end

    caw_fout_div u_fout (
        .mclk_i(mclk_i),
        .rst_n_i(rst_n),
        .osc_edge_i(osc_edge),
        .en_i(trim_q[TRIM_FOUT_EN_BIT]),
        .fout_o(freq_out_pin_o)
    );

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    property p_no_enable_no_flag;
        @(posedge mclk_i) disable iff (!rst_n)
        (ctrl_q[7:4] == 4'h0) |=> !flag_q;
    endproperty
    a_no_enable_no_flag: assert property (p_no_enable_no_flag)
        else $error("flag set with all compares disabled");

    property p_flag_sticky;
        @(posedge mclk_i) disable iff (!rst_n)
        (flag_q && !sw_clr && (|cmp_en)) |=> flag_q;
    endproperty
    a_flag_sticky: assert property (p_flag_sticky)
        else $error("alarm flag dropped without clear");

    property p_tick_match_sets;
        @(posedge mclk_i) disable iff (!rst_n)
        (tick && match) |=> flag_q;
    endproperty
    a_tick_match_sets: assert property (p_tick_match_sets)
        else $error("tick match did not set flag");

    property p_bad_range;
        @(posedge mclk_i) disable iff (!rst_n)
        (cmp_en[2] && alm_q[2] > MIN_MAX) |-> !match;
    endproperty
    a_bad_range: assert property (p_bad_range)
        else $error("out of range minute matched");

    property p_one_per_tick;
        @(posedge mclk_i) disable iff (!rst_n)
        (fired_q && !tick) |-> !fire;
    endproperty
    a_one_per_tick: assert property (p_one_per_tick)
        else $error("second alarm in one tick");

    property p_wday_hold;
        @(posedge mclk_i) disable iff (!rst_n)
        (hour_roll_i && !wr_hour && wday_q == 3'h0) |=> wday_q == 3'h0;
    endproperty
    a_wday_hold: assert property (p_wday_hold)
        else $error("weekday left zero");

    property p_wday_wrap;
        @(posedge mclk_i) disable iff (!rst_n)
        (hour_roll_i && !wr_hour && wday_q == 3'h7) |=> wday_q == 3'h1;
    endproperty
    a_wday_wrap: assert property (p_wday_wrap)
        else $error("weekday did not wrap to one");

    property p_trim_bad;
        @(posedge mclk_i) disable iff (!rst_n)
        (wr_trim && !trim_good) |=> (trim_q[5:0] == TRIM_BAD_VALUE[5:0])
            && !trim_q[7] && trim_q[6] == $past(trim_q[6]);
    endproperty
    a_trim_bad: assert property (p_trim_bad)
        else $error("bad trim write not forced");

    property p_retention_ignore;
        @(posedge mclk_i) disable iff (!rst_n)
        (sfr_req_i.wr && retention && sfr_req_i.addr == OFS_CTRL)
            |=> $stable(ctrl_q);
    endproperty
    a_retention_ignore: assert property (p_retention_ignore)
        else $error("write taken during retention");

    c_alarm_fire: cover property (@(posedge mclk_i) disable iff (!rst_n)
        fire);
    c_async_fire: cover property (@(posedge mclk_i) disable iff (!rst_n)
        fire && !tick);
    c_wday_wrap: cover property (@(posedge mclk_i) disable iff (!rst_n)
        hour_roll_i && wday_q == 3'h7);
endmodule : caw_alarm

// file: tb/tb.sv
// tb: self-checking bench for the clock alarm, weekday and trim block
// assumes caw_alarm as top; oscillator driven fast to keep ticks short
`timescale 1ns/1ps
module tb;
    import caw_pkg::*;
    logic mclk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic xtal_in_i = 1'b0;
    logic retention_i = 1'b0;
    logic hour_roll_i = 1'b0;
    caw_sfr_req_t sfr_req_i = '0;
    caw_time_t time_i = '0;
    logic [7:0] sfr_rdata_o;
    logic alarm_irq_o, tick_o, load_cap_select_o;
    logic [2:0] weekday_field_o, trim_value_bits_o;
    logic freq_out_pin_o, freq_out_pin_oe_o;
    integer err_count = 0, n_compared = 0, seed = 93, cycles = 0;
    logic [7:0] tv [4];
    logic [7:0] alm [4];
    logic [7:0] lim [4];
    logic [7:0] rd;
    logic [3:0] en;
    logic [2:0] wd;
    logic m, prev;
    integer cnt;
    logic [15:0] trim_tab [3] = '{16'hff65, 16'h2626, 16'h3f25};

    caw_alarm caw_alarm_i (.mclk_i(mclk_i), .rst_b_i(rst_b_i),
        .xtal_in_i(xtal_in_i), .retention_i(retention_i),
        .sfr_req_i(sfr_req_i), .time_i(time_i), .hour_roll_i(hour_roll_i),
        .sfr_rdata_o(sfr_rdata_o), .alarm_irq_o(alarm_irq_o),
        .tick_o(tick_o), .weekday_field_o(weekday_field_o),
        .load_cap_select_o(load_cap_select_o),
        .trim_value_bits_o(trim_value_bits_o),
        .freq_out_pin_o(freq_out_pin_o),
        .freq_out_pin_oe_o(freq_out_pin_oe_o));

    // ----------------------------------------
    // clocks and timeout
    // ----------------------------------------
    initial begin
        forever #20 mclk_i = ~mclk_i;
    end
    // oscillator period of 8 core cycles: tick every 1024 cycles
    always begin
        repeat (4) @(posedge mclk_i);
        #1 xtal_in_i = ~xtal_in_i;
    end
    always @(posedge mclk_i) begin
        cycles++;
        if (cycles == 60000) begin
            err_count++;
            finish_test();
        end
    end

    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic finish_test();
        $display("errors %0d compared %0d", err_count, n_compared);
        if (err_count == 0 && n_compared > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : finish_test
    task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                       input string msg);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: %s got %h exp %h",
                     $time, msg, got, exp);
        end
    endtask : chk
    task automatic cyc(input integer n);
        repeat (n) @(posedge mclk_i);
        #1;
    endtask : cyc
    task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
        sfr_req_i.wr = 1'b1;
        sfr_req_i.addr = a;
        sfr_req_i.wdata = d;
        cyc(1);
        sfr_req_i.wr = 1'b0;
        cyc(1);
    endtask : sfr_wr
    task automatic sfr_rd(input logic [7:0] a, output logic [7:0] d);
        sfr_req_i.rd = 1'b1;
        sfr_req_i.addr = a;
        cyc(1);
        sfr_req_i.rd = 1'b0;
        d = sfr_rdata_o;
        cyc(1);
    endtask : sfr_rd
    task automatic wait_tick();
        integer i;
        for (i = 0; i < 2000 && tick_o !== 1'b1; i++) cyc(1);
        chk({7'h0, tick_o}, 8'h01, "tick");
    endtask : wait_tick
    task automatic roll();
        hour_roll_i = 1'b1;
        cyc(1);
        hour_roll_i = 1'b0;
        cyc(2);
    endtask : roll
    function automatic logic fmatch(input logic [3:0] e);
        fmatch = (e != 4'h0);
        for (int i = 0; i < 4; i++)
            if (e[3-i] && (alm[i] !== tv[i] || alm[i] > lim[i]))
                fmatch = 1'b0;
    endfunction : fmatch
    function automatic logic [2:0] next_wd(input logic [2:0] w);
        next_wd = (w == WDAY_OFF) ? WDAY_OFF :
                  (w == WDAY_LAST) ? WDAY_FIRST : w + 3'h1;
    endfunction : next_wd

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        lim = '{SUBSEC_MAX, SEC_MAX, MIN_MAX, {3'h0, HOUR_MAX}};
        repeat (8) @(posedge mclk_i);
        #1 rst_b_i = 1'b1;
        cyc(4);
        sfr_rd(OFS_TRIM, rd);
        chk(rd, TRIM_RST, "trim reset");
        chk({7'h0, load_cap_select_o}, 8'h01, "cap reset");
        sfr_rd(OFS_CTRL, rd);
        chk(rd, CTRL_RST, "ctrl reset");
        // trim: good write drives the pin, bad complement forces default
        sfr_wr(OFS_TRIM, 8'he6);
        sfr_rd(OFS_TRIM, rd);
        chk(rd, 8'he6, "trim good");
        chk({5'h0, trim_value_bits_o}, 8'h05, "trim bits");
        chk({7'h0, freq_out_pin_oe_o}, 8'h01, "pin oe");
        cnt = 0;
        prev = freq_out_pin_o;
        repeat (640) begin
            cyc(1);
            if (freq_out_pin_o === 1'b1 && prev === 1'b0) cnt++;
            prev = freq_out_pin_o;
        end
        chk({7'h0, cnt >= 9 && cnt <= 11}, 8'h01, "fout rate");
        foreach (trim_tab[k]) begin
            sfr_wr(OFS_TRIM, trim_tab[k][15:8]);
            sfr_rd(OFS_TRIM, rd);
            chk(rd, trim_tab[k][7:0], "trim force");
            chk({7'h0, load_cap_select_o}, {7'h0, rd[6]}, "cap");
            chk({7'h0, freq_out_pin_oe_o}, 8'h00, "oe off");
            chk({7'h0, freq_out_pin_o}, 8'h00, "pin idle");
        end
        // weekday counting, wrap and hold at zero
        wd = 3'h6;
        sfr_wr(OFS_HOUR_CNT, {wd, 5'h00});
        for (int k = 0; k < 7; k++) begin
            if (k == 4) begin
                wd = WDAY_OFF;
                sfr_wr(OFS_HOUR_CNT, 8'h00);
            end
            roll();
            wd = next_wd(wd);
            chk({5'h0, weekday_field_o}, {5'h0, wd}, "weekday");
        end
        // random alarm trials, first one an out-of-range corner
        for (int t = 0; t < 12; t++) begin
            sfr_wr(OFS_CTRL, 8'h00);
            chk({7'h0, alarm_irq_o}, 8'h00, "flag clr");
            // fresh subsecond, so no earlier alarm suppresses this one
            wait_tick();
            for (int i = 0; i < 4; i++) begin
                tv[i] = $random(seed) % ({24'h0, lim[i]} + 1);
                alm[i] = $random(seed) % 2 ? tv[i] :
                         $random(seed) % ({24'h0, lim[i]} + 1);
            end
            en = 4'h1 + 4'({$random(seed)} % 15);
            if (t == 0) begin
                tv[2] = 8'h3d;
                alm[2] = 8'h3d;
                en = 4'h2;
            end
            if (t == 11) begin
                foreach (alm[i]) alm[i] = tv[i];
                en = 4'hf;
            end
            time_i = {tv[0], tv[1], tv[2], tv[3][4:0]};
            for (int i = 0; i < 4; i++)
                sfr_wr(8'(OFS_ALM_SUBSEC + i), alm[i]);
            sfr_wr(OFS_CTRL, {en, 4'h0});
            cyc(3);
            m = fmatch(en);
            chk({7'h0, alarm_irq_o}, {7'h0, m}, "async");
            sfr_rd(OFS_CTRL, rd);
            chk({7'h0, rd[CTRL_IRQ_FLAG_BIT]}, {7'h0, m}, "flag bit");
            sfr_wr(OFS_CTRL, {en, 4'h0});
            cyc(3);
            chk({7'h0, alarm_irq_o}, 8'h00, "one per tick");
            wait_tick();
            cyc(3);
            chk({7'h0, alarm_irq_o}, {7'h0, m}, "sync");
        end
        // flag kept over one tick, cleared by disabling all compares
        time_i.subsec = tv[0] ^ 8'h01;
        cyc(1100);
        chk({7'h0, alarm_irq_o}, {7'h0, m}, "sticky");
        sfr_wr(OFS_CTRL, 8'h02);
        chk({7'h0, alarm_irq_o}, 8'h00, "all off");
        wait_tick();
        cyc(3);
        chk({7'h0, alarm_irq_o}, 8'h00, "no alarm");
        // alarm in retention, writes refused meanwhile
        alm[3] = tv[3];
        sfr_wr(OFS_ALM_HOUR, alm[3]);
        sfr_wr(OFS_CTRL, 8'h10);
        sfr_wr(OFS_CTRL, 8'h10);
        retention_i = 1'b1;
        wait_tick();
        cyc(3);
        chk({7'h0, alarm_irq_o}, 8'h01, "retention alarm");
        sfr_wr(OFS_CTRL, 8'h00);
        sfr_wr(OFS_TRIM, 8'he6);
        cyc(3);
        chk({7'h0, alarm_irq_o}, 8'h01, "pending");
        retention_i = 1'b0;
        cyc(3);
        sfr_rd(OFS_TRIM, rd);
        chk(rd, 8'h25, "trim kept");
        finish_test();
    end
endmodule : tb
